/* hdl/ldc_pkg.sv */
// ldc_pkg: constants for the long-mode descriptor checker.
// assumes: one 200 MHz clock, wishbone classic register access.
// How it works
// - 64-bit mode code base forced to zero
// - no code limit check, canonical check instead; the checker makes no canonical check on code
// - code readable and accessed bits ignored
// - long bit is upper dword bit 21
// - legacy mode treats long bit reserved
// - long clear keeps legacy sizes, segmentation
// - long set with default-size set reserved
// - all descriptor fields still loaded
// - data, extra, stack base forced zero
// - aux segment registers keep their base
// - no data limit check, default-size unused
// - data expand-down, writable, accessed ignored
// - data privilege level ignored, no check
// - compatibility mode decodes code, data as legacy
// - illegal system type raises protection fault
// - types 2, 9, B are table/task
// - C, E, F gates; others illegal
// - compatibility type 2 is 32-bit table
// - 64-bit mode system entries are 16 bytes
// - expanded load only in 64-bit mode
// - non-canonical system base faults with selector
// - upper dword bits 12:8 must be zero
`default_nettype none
package ldc_pkg;
    // register byte offsets
    localparam logic [7:0] LDC_OFF_CTRL   = 8'h00; // mode control
    localparam logic [7:0] LDC_OFF_DLO    = 8'h04; // descriptor dword +0
    localparam logic [7:0] LDC_OFF_DHI    = 8'h08; // descriptor dword +4
    localparam logic [7:0] LDC_OFF_DX2    = 8'h0c; // descriptor dword +8
    localparam logic [7:0] LDC_OFF_DX3    = 8'h10; // descriptor dword +12
    localparam logic [7:0] LDC_OFF_SEL    = 8'h14; // selector and kind
    localparam logic [7:0] LDC_OFF_STAT   = 8'h18; // result status
    localparam logic [7:0] LDC_OFF_BASELO = 8'h1c; // effective base low
    localparam logic [7:0] LDC_OFF_BASEHI = 8'h20; // effective base high
    localparam logic [7:0] LDC_OFF_LIMIT  = 8'h24; // effective limit
    localparam logic [7:0] LDC_OFF_ERR    = 8'h28; // fault error code
    localparam logic [7:0] LDC_OFF_FSB    = 8'h2c; // aux a 64-bit base low
    localparam logic [7:0] LDC_OFF_FSBH   = 8'h30; // aux a base high
    localparam logic [7:0] LDC_OFF_GSB    = 8'h34; // aux b base low
    localparam logic [7:0] LDC_OFF_GSBH   = 8'h38; // aux b base high
    localparam int unsigned LDC_NREG      = 15;    // registers in map
    // control bits
    localparam int LDC_CTRL_LMA = 0;               // long mode active
    localparam int LDC_CTRL_CSL = 1;               // current code long bit
    // descriptor field positions in upper dword
    localparam int LDC_BIT_G    = 23;
    localparam int LDC_BIT_D    = 22;
    localparam int LDC_BIT_L    = 21;
    localparam int LDC_BIT_S    = 12;
    localparam int LDC_TYPE_LO  = 8;
    // segment-register kinds in SEL[18:16]
    localparam logic [2:0] LDC_SEG_CODE  = 3'h0;
    localparam logic [2:0] LDC_SEG_DS    = 3'h1;
    localparam logic [2:0] LDC_SEG_ES    = 3'h2;
    localparam logic [2:0] LDC_SEG_SS    = 3'h3;
    localparam logic [2:0] LDC_SEG_AUXA  = 3'h4;
    localparam logic [2:0] LDC_SEG_AUXB  = 3'h5;
    localparam logic [2:0] LDC_SEG_LTAB  = 3'h6; // local table register load
    localparam logic [2:0] LDC_SEG_TASK  = 3'h7; // task register load
    // long-mode system types
    localparam logic [3:0] LDC_T_LDT   = 4'h2;
    localparam logic [3:0] LDC_T_TSSA  = 4'h9;
    localparam logic [3:0] LDC_T_TSSB  = 4'hb;
    localparam logic [3:0] LDC_T_CALL  = 4'hc;
    localparam logic [3:0] LDC_T_INTG  = 4'he;
    localparam logic [3:0] LDC_T_TRAP  = 4'hf;
    // status bit positions
    localparam int LDC_ST_DONE = 0;
    localparam int LDC_ST_GP   = 1;
    localparam int LDC_ST_M64  = 2;
    localparam int LDC_ST_LCHK = 3;  // limit check applies
    localparam int LDC_ST_PCHK = 4;  // privilege check applies
    localparam int LDC_ST_EXP  = 5;  // 16-byte system entry
    localparam int LDC_ST_RSV  = 6;  // reserved long/default combo
    localparam int LDC_ST_OP32 = 7;  // default operand 32
    localparam int LDC_ST_AD64 = 8;  // default address 64
    localparam int LDC_ST_SEGEN = 9; // segmentation enabled
    localparam int LDC_ST_LT32 = 10; // type 2 read as 32-bit table
    localparam logic [31:0] LDC_RST_WORD = 32'h0000_0000;
    localparam int LDC_VA_BITS = 48; // implemented virtual-address width
    // result states
    typedef enum logic [2:0] {
        LDC_IDLE = 3'b001,
        LDC_EVAL = 3'b010,
        LDC_DONE = 3'b100
    } ldc_state_type;
endpackage
`default_nettype wire

/* hdl/ldc_canon.sv */
// ldc_canon: canonical-form check of a 64-bit address.
// assumes: pure combinational use inside the checker.
`default_nettype none
module ldc_canon
(
    input  wire logic [63:0] addr_i,   // address under test
    output logic             canon_o   // high when canonical
);
    import ldc_pkg::*;
    // upper bits must all copy the top implemented bit
    always_comb
    begin
        canon_o = (addr_i[63:LDC_VA_BITS-1] == '0) || (&addr_i[63:LDC_VA_BITS-1]);
    end
endmodule // ldc_canon
`default_nettype wire

/* hdl/ldc_regs.sv */
// ldc_regs: small register store with a registered read port.
// assumes: single writer, index decoded by the caller.
`default_nettype none
module ldc_regs
(
    input  wire logic        clk_i,    // core clock
    input  wire logic        rst_i,    // sync reset
    input  wire logic        we_i,     // write strobe
    input  wire logic [3:0]  sel_i,    // byte enables
    input  wire logic [3:0]  widx_i,   // write index
    input  wire logic [31:0] wdat_i,   // write data
    input  wire logic [3:0]  ridx_i,   // read index
    output logic [31:0]      rdat_o,   // registered read data
    output logic [31:0]      w0_o,     // word 0 view
    output logic [31:0]      w1_o,     // word 1 view
    output logic [31:0]      w2_o,     // word 2 view
    output logic [31:0]      w3_o,     // word 3 view
    output logic [31:0]      w4_o,     // word 4 view
    output logic [31:0]      w5_o      // word 5 view
);
    import ldc_pkg::*;
    // byte lanes, one generate slice each; a lane owns its storage and
    // its read flop, so no variable is written by two processes
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            logic [7:0] q_ff [0:15]; // this lane of every word
            logic [7:0] rd_ff;       // this lane of the read data
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    for (int k = 0; k < 16; k++)
                        q_ff[k] <= LDC_RST_WORD[gb*8 +: 8];
                end
                else if (we_i && sel_i[gb])
                begin
                    q_ff[widx_i] <= wdat_i[gb*8 +: 8];
                end
            end
            // read data out of a flop
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    rd_ff <= LDC_RST_WORD[gb*8 +: 8];
                else
                    rd_ff <= q_ff[ridx_i];
            end
        end
    endgenerate
    // lanes joined back into words
    assign rdat_o = {g_lane[3].rd_ff, g_lane[2].rd_ff, g_lane[1].rd_ff, g_lane[0].rd_ff};
    assign w0_o   = {g_lane[3].q_ff[0], g_lane[2].q_ff[0], g_lane[1].q_ff[0], g_lane[0].q_ff[0]};
    assign w1_o   = {g_lane[3].q_ff[1], g_lane[2].q_ff[1], g_lane[1].q_ff[1], g_lane[0].q_ff[1]};
    assign w2_o   = {g_lane[3].q_ff[2], g_lane[2].q_ff[2], g_lane[1].q_ff[2], g_lane[0].q_ff[2]};
    assign w3_o   = {g_lane[3].q_ff[3], g_lane[2].q_ff[3], g_lane[1].q_ff[3], g_lane[0].q_ff[3]};
    assign w4_o   = {g_lane[3].q_ff[4], g_lane[2].q_ff[4], g_lane[1].q_ff[4], g_lane[0].q_ff[4]};
    assign w5_o   = {g_lane[3].q_ff[5], g_lane[2].q_ff[5], g_lane[1].q_ff[5], g_lane[0].q_ff[5]};
endmodule // ldc_regs
`default_nettype wire

/* hdl/ldc_top.sv */
// ldc_top: long-mode descriptor checker with a wishbone classic slave.
// assumes: software writes descriptor words, selector and mode, then
// writes the selector register to start a check; results read back.
`default_nettype none
module ldc_top
(
    input  wire logic        clk_i,     // core clock, 200 MHz
    input  wire logic        rst_i,     // sync reset, active high
    input  wire logic        cyc_i,     // wishbone cycle
    input  wire logic        stb_i,     // wishbone strobe
    input  wire logic        we_i,      // wishbone write
    input  wire logic [7:0]  adr_i,     // byte address
    input  wire logic [3:0]  sel_i,     // byte enables
    input  wire logic [31:0] dat_i,     // write data
    output logic [31:0]      dat_o,     // read data
    output logic             ack_o,     // acknowledge
    output logic             err_o,     // unmapped address
    output logic             gp_fault_o // protection fault level
);
    import ldc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // bus decode
    logic        req;          // live request
    logic        ack_ff;       // answer flag
    logic        hit;          // mapped address
    logic        wr_in;        // writable input word
    logic [3:0]  idx;          // word index
    logic        rd_ro;        // read from result side
    logic [31:0] ro_dat_ff;    // registered result read
    logic        err_ff;       // error answer
    assign req   = cyc_i && stb_i && !ack_ff && !err_ff;
    assign idx   = adr_i[5:2];
    assign hit   = (adr_i[1:0] == 2'h0) && (adr_i <= LDC_OFF_GSBH);
    assign wr_in = (adr_i <= LDC_OFF_SEL) || (adr_i >= LDC_OFF_FSB);
    assign rd_ro = (adr_i >= LDC_OFF_STAT) && (adr_i <= LDC_OFF_ERR);

    // one-cycle answer, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= req && hit;
            err_ff <= req && !hit;
        end
    end
    assign ack_o = ack_ff;
    assign err_o = err_ff;

    ////////////////////////////////////////////////////////////////
    // input word store
    logic [31:0] rf_rdat;                  // store read data
    logic [31:0] ctrl_w;                   // mode control
    logic [31:0] dlo_w, dhi_w, dx2_w, dx3_w; // descriptor words
    logic [31:0] sel_w;                    // selector and kind
    logic [31:0] fsb_lo_ff, fsb_hi_ff;     // aux a base
    logic [31:0] gsb_lo_ff, gsb_hi_ff;     // aux b base
    logic        wr_go;                    // store write
    assign wr_go = req && hit && we_i && wr_in && (adr_i <= LDC_OFF_SEL);

    ldc_regs u_regs
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .we_i   (wr_go),
        .sel_i  (sel_i),
        .widx_i (idx),
        .wdat_i (dat_i),
        .ridx_i (idx),
        .rdat_o (rf_rdat),
        .w0_o   (ctrl_w),
        .w1_o   (dlo_w),
        .w2_o   (dhi_w),
        .w3_o   (dx2_w),
        .w4_o   (dx3_w),
        .w5_o   (sel_w)
    );

    // aux base registers, 64-bit wide as from model-specific store
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fsb_lo_ff <= LDC_RST_WORD;
            fsb_hi_ff <= LDC_RST_WORD;
            gsb_lo_ff <= LDC_RST_WORD;
            gsb_hi_ff <= LDC_RST_WORD;
        end
        else if (req && hit && we_i)
        begin
            if (adr_i == LDC_OFF_FSB)  fsb_lo_ff <= dat_i;
            if (adr_i == LDC_OFF_FSBH) fsb_hi_ff <= dat_i;
            if (adr_i == LDC_OFF_GSB)  gsb_lo_ff <= dat_i;
            if (adr_i == LDC_OFF_GSBH) gsb_hi_ff <= dat_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // field extraction
    logic       lma;        // long mode active
    logic       m64;        // 64-bit execution
    logic       compat;     // compatibility execution
    logic [2:0] kind;       // segment-register kind
    logic [3:0] typ;        // type field
    logic       s_bit;      // code/data vs system
    logic       l_bit, d_bit, g_bit;
    logic [31:0] leg_base;  // legacy 32-bit base
    logic [19:0] raw_lim;   // raw limit field
    logic [31:0] leg_lim;   // scaled limit
    logic [63:0] sys_base;  // expanded system base
    logic        sys_canon; // canonical system base
    logic [63:0] aux_base;  // aux register base
    logic        start;     // selector write kicks a check

    assign lma      = ctrl_w[LDC_CTRL_LMA];
    assign l_bit    = dhi_w[LDC_BIT_L];
    assign d_bit    = dhi_w[LDC_BIT_D];
    assign g_bit    = dhi_w[LDC_BIT_G];
    assign s_bit    = dhi_w[LDC_BIT_S];
    assign typ      = dhi_w[LDC_TYPE_LO +: 4];
    assign kind     = sel_w[18:16];
    // long bit of the running code segment; legacy mode masks it
    assign m64      = lma && ctrl_w[LDC_CTRL_CSL];
    assign compat   = lma && !m64;
    assign leg_base = {dhi_w[31:24], dhi_w[7:0], dlo_w[31:16]};
    assign raw_lim  = {dhi_w[19:16], dlo_w[15:0]};
    assign leg_lim  = g_bit ? {raw_lim, 12'hfff} : {12'h000, raw_lim};
    assign sys_base = {dx2_w, leg_base};
    assign aux_base = (kind == LDC_SEG_AUXA) ? {fsb_hi_ff, fsb_lo_ff}
                                             : {gsb_hi_ff, gsb_lo_ff};
    assign start    = wr_go && (adr_i == LDC_OFF_SEL);

    ldc_canon u_canon
    (
        .addr_i  (sys_base),
        .canon_o (sys_canon)
    );

    ////////////////////////////////////////////////////////////////
    // evaluation
    logic        n_gp;      // fault
    logic [31:0] n_err;     // fault code
    logic [63:0] n_base;    // effective base
    logic [31:0] n_lim;     // effective limit
    logic        n_lchk, n_pchk, n_exp, n_rsv, n_op32, n_ad64, n_segen, n_lt32;
    logic        sys_seg;   // system descriptor load

    always_comb
    begin
        sys_seg = (kind == LDC_SEG_LTAB) || (kind == LDC_SEG_TASK);
        n_gp    = 1'b0;
        n_err   = 32'h0000_0000;
        n_base  = {32'h0000_0000, leg_base};
        n_lim   = leg_lim;
        n_lchk  = 1'b1;
        n_pchk  = 1'b1;
        n_exp   = 1'b0;
        n_rsv   = 1'b0;
        n_op32  = d_bit;
        n_ad64  = 1'b0;
        n_segen = 1'b1;
        n_lt32  = 1'b0;
        if (!sys_seg)
        begin
            // code and data; compatibility keeps legacy values
            if (m64)
            begin
                n_segen = 1'b0;
                n_lchk  = 1'b0;
                n_lim   = 32'hffff_ffff;
                if (kind == LDC_SEG_CODE)
                begin
                    n_base = 64'h0;
                    n_op32 = 1'b1;
                    n_ad64 = 1'b1;
                    n_rsv  = d_bit;
                    n_gp   = d_bit;
                end
                else if (kind == LDC_SEG_AUXA || kind == LDC_SEG_AUXB)
                begin
                    n_base = aux_base;
                    n_pchk = 1'b0;
                end
                else
                begin
                    n_base = 64'h0;
                    n_pchk = 1'b0;
                end
            end
            else if (kind == LDC_SEG_CODE && lma && l_bit && d_bit)
            begin
                n_rsv = 1'b1;
                n_gp  = 1'b1;
            end
            else if (kind == LDC_SEG_CODE)
            begin
                n_op32 = d_bit;
            end
        end
        else if (lma)
        begin
            // long-mode system types; gates pass the type check but fault as a table or task load
            if (s_bit || !(typ == LDC_T_LDT || typ == LDC_T_TSSA || typ == LDC_T_TSSB
                || typ == LDC_T_CALL || typ == LDC_T_INTG || typ == LDC_T_TRAP))
            begin
                n_gp  = 1'b1;
                n_err = {16'h0000, sel_w[15:0]};
            end
            else if ((kind == LDC_SEG_LTAB) != (typ == LDC_T_LDT) ||
                     (typ != LDC_T_LDT && typ != LDC_T_TSSA && typ != LDC_T_TSSB))
            begin
                n_gp  = 1'b1;
                n_err = {16'h0000, sel_w[15:0]};
            end
            else if (m64)
            begin
                n_exp  = 1'b1;
                n_base = sys_base;
                if (dx3_w[12:8] != 5'h00 || !sys_canon)
                begin
                    n_gp  = 1'b1;
                    n_err = {16'h0000, sel_w[15:0]};
                end
            end
            else
            begin
                n_lt32 = (typ == LDC_T_LDT);
            end
        end
        else if (typ == 4'h0 || typ == 4'h8 || typ == 4'ha || typ == 4'hd || s_bit)
        begin
            n_gp  = 1'b1;
            n_err = {16'h0000, sel_w[15:0]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // result registers and state
    ldc_state_type st_ff;
    logic [63:0]   base_ff;
    logic [31:0]   lim_ff, err_code_ff, stat_ff;
    logic          gp_ff;

    // idle -> eval one cycle after start -> done
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= LDC_IDLE;
        else
        begin
            case (st_ff)
                LDC_IDLE: if (start) st_ff <= LDC_EVAL;
                LDC_EVAL: st_ff <= LDC_DONE;
                LDC_DONE: if (start) st_ff <= LDC_EVAL;
                default:  st_ff <= LDC_IDLE;
            endcase
        end
    end

    // capture results; every field kept even if later ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            base_ff     <= 64'h0;
            lim_ff      <= LDC_RST_WORD;
            err_code_ff <= LDC_RST_WORD;
            stat_ff     <= LDC_RST_WORD;
            gp_ff       <= 1'b0;
        end
        else if (start)
        begin
            stat_ff[LDC_ST_DONE] <= 1'b0;
        end
        else if (st_ff == LDC_EVAL)
        begin
            base_ff     <= n_base;
            lim_ff      <= n_lim;
            err_code_ff <= n_err;
            gp_ff       <= n_gp;
            stat_ff     <= {21'h0, n_lt32, n_segen, n_ad64, n_op32, n_rsv,
                            n_exp, n_pchk, n_lchk, m64, n_gp, 1'b1};
        end
    end
    assign gp_fault_o = gp_ff;

    // read mux into a flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ro_dat_ff <= LDC_RST_WORD;
        else
        begin
            case (adr_i)
                LDC_OFF_STAT:   ro_dat_ff <= stat_ff;
                LDC_OFF_BASELO: ro_dat_ff <= base_ff[31:0];
                LDC_OFF_BASEHI: ro_dat_ff <= base_ff[63:32];
                LDC_OFF_LIMIT:  ro_dat_ff <= lim_ff;
                LDC_OFF_ERR:    ro_dat_ff <= err_code_ff;
                LDC_OFF_FSB:    ro_dat_ff <= fsb_lo_ff;
                LDC_OFF_FSBH:   ro_dat_ff <= fsb_hi_ff;
                LDC_OFF_GSB:    ro_dat_ff <= gsb_lo_ff;
                LDC_OFF_GSBH:   ro_dat_ff <= gsb_hi_ff;
                default:        ro_dat_ff <= LDC_RST_WORD;
            endcase
        end
    end
    assign dat_o = (rd_ro || adr_i >= LDC_OFF_FSB) ? ro_dat_ff : rf_rdat;
endmodule // ldc_top
`default_nettype wire

/* tb/ldc_chk.sv */
// ldc_chk: port-level checks for ldc_top, bound from the bench.
// assumes: one clock, sync active-high reset, wishbone classic master.
`default_nettype none
module ldc_chk
(
    input wire logic        clk_i,      // core clock
    input wire logic        rst_i,      // sync reset
    input wire logic        cyc_i,      // bus cycle
    input wire logic        stb_i,      // bus strobe
    input wire logic        we_i,       // bus write
    input wire logic [7:0]  adr_i,      // byte address
    input wire logic [3:0]  sel_i,      // byte enables
    input wire logic [31:0] dat_i,      // write data
    input wire logic [31:0] dat_o,      // read data
    input wire logic        ack_o,      // acknowledge
    input wire logic        err_o,      // unmapped access
    input wire logic        gp_fault_o  // fault level
);
    import ldc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic       req;    // fresh request, no answer showing
    logic       sel_wr; // selector write acknowledged; check launched the cycle before
    logic [2:0] age_ff; // cycles since launch, saturates
    assign req    = cyc_i && stb_i && !ack_o && !err_o;
    assign sel_wr = ack_o && we_i && (adr_i == LDC_OFF_SEL);
    // age counter bounds when the fault level may move
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            age_ff <= 3'h7;
        else if (sel_wr)
            age_ff <= 3'h0;
        else if (age_ff != 3'h7)
            age_ff <= age_ff + 3'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ANSWER_NEXT: assert property (req |=> (ack_o || err_o))
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ONE_ANSWER: assert property (!(ack_o && err_o))
        else $error("ack and err together");
    AST_ERR_UNALIGNED: assert property (req && adr_i[1:0] != 2'h0 |=> err_o && !ack_o)
        else $error("unaligned access not refused");
    AST_ERR_RANGE: assert property (req && adr_i > 8'h38 |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    AST_MAPPED_ACK: assert property (req && adr_i[1:0] == 2'h0 && adr_i <= 8'h38 |=> ack_o)
        else $error("mapped access not acknowledged");
    AST_GP_TIMING: assert property (!$stable(gp_fault_o) |-> age_ff <= 3'h4)
        else $error("fault level moved without a check");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !ack_o && !err_o && !gp_fault_o)
        else $error("outputs not quiet after reset");
    COV_CHECK: cover property (sel_wr);
    COV_REFUSE: cover property (err_o);
    COV_FAULT: cover property ($rose(gp_fault_o));
endmodule // ldc_chk
`default_nettype wire

/* tb/ldc_top_bench.sv */
// ldc_top_bench: directed bench for ldc_top over wishbone classic.
// assumes: checker ldc_chk compiled before, bound below.
`default_nettype none
module ldc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ldc_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, e; // bus drive, err seen
    logic [7:0]  adr_i;                            // byte address
    logic [3:0]  sel_i;                            // byte enables
    logic [31:0] dat_i, dat_o, st, q;              // data, status, read
    logic        ack_o, err_o, gp_fault_o;         // design answers
    int          bad_count, tests_run;             // tallies
    ldc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .gp_fault_o(gp_fault_o));
    // 200 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            bad_count++;
        end
    endtask
    // one classic cycle; held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic x);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            test_done();
        end
        r = dat_o;
        x = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    // load mode and descriptor, launch, poll for done
    task automatic run(input logic [31:0] c, lo, hi, x2, x3, s);
        int n;
        wb(1'b1, LDC_OFF_CTRL, c, q, e);
        wb(1'b1, LDC_OFF_DLO, lo, q, e);
        wb(1'b1, LDC_OFF_DHI, hi, q, e);
        wb(1'b1, LDC_OFF_DX2, x2, q, e);
        wb(1'b1, LDC_OFF_DX3, x3, q, e);
        wb(1'b1, LDC_OFF_SEL, s, q, e);
        n  = 0;
        st = 32'h0;
        while (st[0] !== 1'b1 && n < 20)
        begin
            wb(1'b0, LDC_OFF_STAT, 32'h0, st, e);
            n++;
        end
        if (n >= 20)
        begin
            bad_count++;
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // code descriptors across 64-bit, compatibility and legacy modes
    task automatic t_code();
        run(32'h3, 32'h5678_ffff, 32'h122f_9a34, 32'h0, 32'h0, 32'h0);
        chk(st & 32'h3cf, 32'h185);
        wb(1'b0, LDC_OFF_BASELO, 32'h0, q, e);
        chk(q, 32'h0);
        wb(1'b0, LDC_OFF_LIMIT, 32'h0, q, e);
        chk(q, 32'hffff_ffff);
        wb(1'b0, LDC_OFF_DHI, 32'h0, q, e);
        chk(q, 32'h122f_9a34);
        run(32'h3, 32'h5678_ffff, 32'h122f_9834, 32'h0, 32'h0, 32'h0);
        chk(st & 32'h3cf, 32'h185);
        run(32'h3, 32'h5678_ffff, 32'h126f_9a34, 32'h0, 32'h0, 32'h0);
        chk(st & 32'h40, 32'h40);
        run(32'h1, 32'h5678_ffff, 32'h120f_9a34, 32'h0, 32'h0, 32'h0);
        chk(st & 32'h3cf, 32'h209);
        wb(1'b0, LDC_OFF_BASELO, 32'h0, q, e);
        chk(q, 32'h1234_5678);
        wb(1'b0, LDC_OFF_LIMIT, 32'h0, q, e);
        chk(q, 32'h000f_ffff);
        run(32'h0, 32'h5678_ffff, 32'h122f_9a34, 32'h0, 32'h0, 32'h0);
        chk(st & 32'h204, 32'h200);
    endtask
    // data, extra and stack kinds with nonzero base, privilege level 3
    task automatic t_data();
        for (int k = 1; k < 4; k++)
        begin
            run(32'h3, 32'h5678_ffff, 32'h12cf_f234, 32'h0, 32'h0,
                {13'h0, 3'(k), 16'h0033});
            chk(st & 32'h18, 32'h0);
            wb(1'b0, LDC_OFF_BASELO, 32'h0, q, e);
            chk(q, 32'h0);
        end
    endtask
    // every system type as a table or task load, then base and upper-word faults
    task automatic t_sys();
        logic ok;
        for (int t = 0; t < 16; t++)
        begin
            ok = (t == 2 || t == 9 || t == 11);
            run(32'h3, 32'h0000_0067, 32'h8000 | (32'(t) << 8), 32'h0, 32'h0,
                (t == 9 || t == 11) ? 32'h0007_0010 : 32'h0006_0010);
            chk({31'h0, st[1]}, {31'h0, !ok});
            chk({31'h0, gp_fault_o}, {31'h0, !ok});
            if (ok)
                chk({31'h0, st[5]}, 32'h1);
        end
        run(32'h3, 32'h0000_0067, 32'h8900, 32'h0001_0000, 32'h0, 32'h0007_0028);
        chk({31'h0, st[1]}, 32'h1);
        wb(1'b0, LDC_OFF_ERR, 32'h0, q, e);
        chk(q, 32'h0000_0028);
        run(32'h3, 32'h0000_0067, 32'h8900, 32'h0, 32'h0000_0100, 32'h0007_0028);
        chk({31'h0, st[1]}, 32'h1);
        run(32'h1, 32'h0000_0067, 32'h8200, 32'h0, 32'h0, 32'h0006_0010);
        chk(st & 32'h422, 32'h400);
    endtask
    // aux base store and refused addresses
    task automatic t_bus();
        wb(1'b1, LDC_OFF_FSB, 32'hdead_beef, q, e);
        wb(1'b0, LDC_OFF_FSB, 32'h0, q, e);
        chk(q, 32'hdead_beef);
        chk({31'h0, e}, 32'h0); // mapped, no refusal
        run(32'h3, 32'h5678_ffff, 32'h12cf_f234, 32'h0, 32'h0, 32'h0004_0000);
        wb(1'b0, LDC_OFF_BASELO, 32'h0, q, e);
        chk(q, 32'hdead_beef);
        wb(1'b0, 8'h3c, 32'h0, q, e);
        chk({31'h0, e}, 32'h1); // unmapped refused
        wb(1'b1, 8'h02, 32'h1, q, e);
        chk({31'h0, e}, 32'h1); // unaligned refused
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        sel_i     = 4'hf;
        rst_i     = 1'b1;
        bad_count = 0;
        tests_run = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_code();
        t_data();
        t_sys();
        t_bus();
        test_done();
    end
endmodule // ldc_top_bench
bind ldc_top ldc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .gp_fault_o(gp_fault_o));
`default_nettype wire
